// ---- core/swd_pkg.sv ----
// Shared constants and types for the single-wire debug link ends.
// Assumes one 50 MHz clock per end and a synchronous active-high reset.
package swd_pkg;

    // ************************************************************
    // Bit timing, in debug clock cycles
    // ************************************************************
    localparam int unsigned BIT_CYCLES      = 16;  // Nominal bit length
    localparam int unsigned SAMPLE_CYCLES   = 10;  // Target sample point
    localparam int unsigned SPEEDUP_ONE     = 7;   // Speed-up pulse for a 1
    localparam int unsigned LOW_ZERO        = 13;  // Low time for a 0
    localparam int unsigned TIMEOUT_CYCLES  = 512; // Idle abort limit
    localparam int unsigned HOST_LOW_CYCLES = 2;   // Host start low time
    localparam int unsigned SYNC_LOW_CYCLES = 128; // Sync request low time
    localparam int unsigned SYNC_PULSE      = 128; // Sync answer low time
    localparam int unsigned CMD_BITS        = 8;   // Command code length
    localparam int unsigned DELAY_CYCLES    = 16;  // Command delay

    // ************************************************************
    // Command codes and classes
    // ************************************************************
    localparam logic [7:0] CMD_ENTER_BG = 8'h90; // Request background mode
    localparam logic [7:0] CMD_GO       = 8'h08; // Leave background mode
    localparam logic [7:0] CMD_CLASS_NI = 8'h80; // Bit 7 set: non-intrusive

    // Target line states
    typedef enum logic [4:0] {
        SWD_IDLE  = 5'b00001,
        SWD_RECV  = 5'b00010,
        SWD_SEND  = 5'b00100,
        SWD_SYNCW = 5'b01000,
        SWD_SYNCA = 5'b10000
    } swd_tstate_type;

endpackage

// ---- core/swd_link_if.sv ----
// Wire-level interface joining target and host ends of the debug wire.
// Resolves the open-drain wire from the two enables; pull-up when idle.
`timescale 1ns/1ps
interface swd_link_if;
    logic tgt_out; // Target drive level
    logic tgt_oe;  // Target drives
    logic hst_out; // Host drive level
    logic hst_oe;  // Host drives
    logic wire_in; // Resolved level

    // Both drivers low-dominant; pull-up when nobody drives
    assign wire_in = (tgt_oe ? tgt_out : 1'b1) & (hst_oe ? hst_out : 1'b1);

    modport target (input wire_in, output tgt_out, output tgt_oe);
    modport host   (input wire_in, output hst_out, output hst_oe);
endinterface

// ---- core/swd_target.sv ----
// Target end of the single-wire debug link: bit engine, command entry.
// Assumes the wire level is resolved in the link interface.
`timescale 1ns/1ps
module swd_target
    import swd_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Debug clock source
    input  wire logic       debug_clock_select,    // 1: alternate source
    input  wire logic       alternate_debug_clock, // Alternate tick enable
    // Control
    input  wire logic       debug_mode_enable,
    input  wire logic       cpu_stopped,           // Core in stop or wait
    // Transmit side
    input  wire logic       tx_valid,              // Bit to return queued
    input  wire logic       tx_bit,
    output logic            tx_ready,              // Bit taken by a host slot
    // Receive side
    output logic            rx_valid,              // One-cycle pulse
    output logic [7:0]      rx_cmd,                // Last command code
    output logic            cmd_abort,             // Timeout pulse
    // System effects
    output logic            background_mode,
    output logic            cpu_wake,
    output logic            reg_cmd_ok,            // Register access allowed
    output logic            watchdog_hold,
    output logic            osc_keep,
    // Wire
    swd_link_if.target      link
);

    // ************************************************************
    // Debug clock tick
    // ************************************************************
    logic tick; // One-cycle enable of the debug clock
    assign tick = debug_clock_select ? alternate_debug_clock : 1'b1;

    // ************************************************************
    // Wire synchroniser and edge detect
    // ************************************************************
    logic sync1;  // First stage, read only by sync2
    logic sync2;  // Stable level
    logic prev;   // Previous stable level
    logic fall;   // Falling edge seen
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            prev  <= 1'b1;
        end else begin
            sync1 <= link.wire_in;
            sync2 <= sync1;
            prev  <= sync2;
        end
    end
    assign fall = prev & ~sync2;

    // ************************************************************
    // Bit engine
    // ************************************************************
    swd_tstate_type state;        // Line state
    logic [9:0]     cnt;          // Cycles since perceived start
    logic [9:0]     idle;         // Cycles since last falling edge
    logic           send_bit;     // Bit being returned
    logic [2:0]     nbits;        // Command bits received
    logic [7:0]     shreg;        // Command shift register
    logic           start;        // Host bit start seen

    // Own sync answer makes a falling edge that must not restart a slot
    assign start = fall & (state != SWD_SYNCA);

    // Sending when a returned bit is queued; host slot else
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state    <= SWD_IDLE;
            cnt      <= '0;
            send_bit <= 1'b0;
        end else if (start) begin
            cnt <= '0;
            if (tx_valid) begin
                state    <= SWD_SEND;
                send_bit <= tx_bit;
            end else begin
                state <= SWD_RECV;
            end
        end else if (tick) begin
            cnt <= (cnt == 10'h3ff) ? cnt : cnt + 10'h001;
            unique case (state)
                SWD_IDLE: begin
                    state <= SWD_IDLE;
                end
                SWD_RECV: begin
                    // Long low marks a sync request
                    if (!sync2 && cnt >= 10'(SYNC_LOW_CYCLES)) begin
                        state <= SWD_SYNCW;
                    end else if (sync2 && cnt >= 10'(BIT_CYCLES)) begin
                        // A wire still low may yet grow into a sync request
                        state <= SWD_IDLE;
                    end
                end
                SWD_SEND: begin
                    if (cnt >= 10'(BIT_CYCLES)) begin
                        state <= SWD_IDLE;
                    end
                end
                SWD_SYNCW: begin
                    // Wait for the host to release the wire
                    if (sync2) begin
                        state <= SWD_SYNCA;
                        cnt   <= '0;
                    end
                end
                SWD_SYNCA: begin
                    // Leave right after the one-cycle speed-up
                    if (cnt >= 10'(SYNC_PULSE)) begin
                        state <= SWD_IDLE;
                    end
                end
            endcase
        end
    end
    assign tx_ready = start & tx_valid;

    // Receive sampling and command shift, MSB first
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nbits    <= '0;
            shreg    <= '0;
            rx_cmd   <= '0;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (cmd_abort || state == SWD_SYNCW) begin
                // A sync request also drops a partial command
                nbits <= '0;
            end else if (tick && state == SWD_RECV
                         && cnt == 10'(SAMPLE_CYCLES - 1)) begin
                shreg <= {shreg[6:0], sync2};
                nbits <= nbits + 3'h1;
                if (nbits == 3'(CMD_BITS - 1)) begin
                    rx_cmd   <= {shreg[6:0], sync2};
                    rx_valid <= 1'b1;
                end
            end
        end
    end

    // Inactivity timeout; no reset needed to talk afterwards
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            idle      <= '0;
            cmd_abort <= 1'b0;
        end else begin
            cmd_abort <= 1'b0;
            if (fall) begin
                idle <= '0;
            end else if (tick && idle != 10'h3ff) begin
                idle <= idle + 10'h001;
                // Only abort a partly received command
                if (idle == 10'(TIMEOUT_CYCLES - 1) && nbits != '0) begin
                    cmd_abort <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Wire drive
    // ************************************************************
    always_comb begin
        link.tgt_oe  = 1'b0;
        link.tgt_out = 1'b1;
        if (state == SWD_SEND) begin
            if (send_bit) begin
                // Brief high at seven; host has released by then
                link.tgt_oe = (cnt == 10'(SPEEDUP_ONE));
            end else if (cnt < 10'(LOW_ZERO)) begin
                link.tgt_oe  = 1'b1;
                link.tgt_out = 1'b0;
            end else begin
                link.tgt_oe = (cnt == 10'(LOW_ZERO));
            end
        end else if (state == SWD_SYNCA) begin
            // Timed low pulse then one speed-up cycle
            link.tgt_oe  = 1'b1;
            link.tgt_out = (cnt >= 10'(SYNC_PULSE));
        end
    end

    // ************************************************************
    // Mode control
    // ************************************************************
    logic strap_done; // Reset-time sample taken
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            background_mode <= 1'b0;
            strap_done      <= 1'b0;
            cpu_wake        <= 1'b0;
        end else begin
            cpu_wake   <= 1'b0;
            strap_done <= 1'b1;
            if (!strap_done) begin
                // Pull-up high means run the application
                // Synchroniser still holds its reset level, so read the pin
                background_mode <= ~link.wire_in;
            end else if (rx_valid) begin
                if (rx_cmd == CMD_ENTER_BG && debug_mode_enable) begin
                    background_mode <= 1'b1;
                    cpu_wake        <= cpu_stopped;
                end else if (rx_cmd == CMD_GO && background_mode) begin
                    background_mode <= 1'b0;
                end
            end
        end
    end

    assign reg_cmd_ok    = background_mode | rx_cmd[7];
    assign watchdog_hold = background_mode;
    assign osc_keep      = debug_mode_enable;

endmodule

// ---- core/swd_host.sv ----
// Host (pod) end of the debug link: one bit per request, either way, or one sync slot per sync request.
// Assumes one bit time of 16 target cycles equals BIT_CYCLES clk ticks.
`timescale 1ns/1ps
module swd_host
    import swd_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Request
    input  wire logic req_valid,
    input  wire logic req_dir,   // 1: send bit, 0: read bit
    input  wire logic req_bit,
    input  wire logic req_sync,  // Sync request instead of a bit
    output logic      req_ready,
    // Answer
    output logic      ans_valid, // One-cycle pulse
    output logic      ans_bit,
    // Wire
    swd_link_if.host  link
);

    // ************************************************************
    // Bit slot sequencer
    // ************************************************************
    logic       busy;  // Slot in progress
    logic       dir;   // Current direction
    logic       dbit;  // Bit to send
    logic       sync;  // Sync slot
    logic [9:0] cnt;   // Slot cycle count
    logic [9:0] len;   // Slot length

    assign req_ready = ~busy;
    assign len = sync ? 10'(SYNC_LOW_CYCLES + 2 + SYNC_PULSE + 8)
                      : 10'(BIT_CYCLES + DELAY_CYCLES / 4);

    // Every slot opens with a falling edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
            dir  <= 1'b0;
            dbit <= 1'b0;
            sync <= 1'b0;
            cnt  <= '0;
        end else if (!busy) begin
            if (req_valid) begin
                busy <= 1'b1;
                dir  <= req_dir;
                dbit <= req_bit;
                sync <= req_sync;
                cnt  <= '0;
            end
        end else begin
            cnt <= cnt + 10'h001;
            if (cnt == len - 10'h001) begin
                busy <= 1'b0;
            end
        end
    end

    // Sample returned bit about ten cycles in
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ans_valid <= 1'b0;
            ans_bit   <= 1'b0;
        end else begin
            ans_valid <= 1'b0;
            if (busy && !dir && !sync && cnt == 10'(SAMPLE_CYCLES + 1)) begin
                ans_valid <= 1'b1;
                ans_bit   <= link.wire_in;
            end
        end
    end

    // ************************************************************
    // Wire drive
    // ************************************************************
    always_comb begin
        link.hst_oe  = 1'b0;
        link.hst_out = 1'b1;
        if (busy) begin
            if (sync) begin
                // Long low, one speed-up cycle, release
                // Extra low cycles cover the target's synchroniser delay
                link.hst_oe  = (cnt <= 10'(SYNC_LOW_CYCLES + 4));
                link.hst_out = (cnt == 10'(SYNC_LOW_CYCLES + 4));
            end else if (dir) begin
                // Drive both levels actively over the bit
                link.hst_oe  = (cnt < 10'(BIT_CYCLES - 1));
                link.hst_out = (cnt >= 10'(HOST_LOW_CYCLES + 1)) & dbit;
            end else begin
                // Low long enough, released before the pulse at seven
                link.hst_oe  = (cnt < 10'(HOST_LOW_CYCLES + 2));
                link.hst_out = 1'b0;
            end
        end
    end

endmodule

// ---- tb/swd_chk.sv ----
// Wire-level assertions for the debug link, fed from the shared interface.
// Assumes the target ticks on every clk while its answers are on the wire.
`timescale 1ns/1ps
module swd_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Drives and resolved level
    input wire logic tgt_out,
    input wire logic tgt_oe,
    input wire logic hst_out,
    input wire logic hst_oe,
    input wire logic wire_in
);
    // ************************************************************
    // Helper counters
    // ************************************************************
    logic [8:0] tlow;   // Target low run
    logic [8:0] hlow;   // Host low run
    logic [9:0] since;  // Cycles since wire fell
    logic       wire_q; // Wire one cycle back

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Target low run, cleared when the drive ends
    always_ff @(posedge clk) begin
        tlow <= (sys_rst || !(tgt_oe && !tgt_out)) ? 9'h000 : tlow + 9'h001;
    end
    // Host low run, sync needs the long ones
    always_ff @(posedge clk) begin
        hlow <= (sys_rst || !(hst_oe && !hst_out)) ? 9'h000 : hlow + 9'h001;
    end
    // Saturates so a long idle never wraps back to a short one
    always_ff @(posedge clk) begin
        if (sys_rst || (wire_q && !wire_in))
            since <= 10'h000;
        else if (since != 10'h3ff)
            since <= since + 10'h001;
    end
    // Idle wire reads high after reset
    always_ff @(posedge clk) begin
        wire_q <= sys_rst ? 1'b1 : wire_in;
    end

    a_zero_low_span: assert property (
        $fell(tgt_oe && !tgt_out) |-> (tlow == 9'h00d || tlow == 9'h080))
        else $error("target low drive has wrong length");
    a_low_then_speedup: assert property (
        $fell(tgt_oe && !tgt_out) |-> tgt_oe && tgt_out)
        else $error("no speed-up after target low");
    a_pulse_brief_high: assert property (
        tgt_oe && tgt_out |=> !(tgt_oe && tgt_out))
        else $error("speed-up pulse too long");
    a_one_pulse_time: assert property (
        (tgt_oe && tgt_out && !$past(tgt_oe)) |-> (since >= 10'h006 && since <= 10'h00d))
        else $error("one pulse at wrong time");
    // Read starts drive four cycles, so five in a row mean a host send or sync
    a_recv_wire_free: assert property (
        hst_oe [*5] |-> !tgt_oe)
        else $error("target drives while host sends");
    a_no_drive_fight: assert property (
        !(tgt_oe && tgt_out && hst_oe && !hst_out))
        else $error("target high against host low");
    a_host_start_low: assert property (
        $rose(hst_oe) |-> !hst_out [*2])
        else $error("host bit start too short");
    a_sync_end_pulse: assert property (
        ($fell(hst_oe && !hst_out) && hlow >= 9'h080) |-> hst_oe && hst_out ##1 !hst_oe)
        else $error("sync end not pulse then release");
endmodule

// ---- tb/swd_link_tb.sv ----
// Self-checking bench: target and host ends joined by the link interface.
// Assumes one 50 MHz clock for both ends and the checker beside the wire.
`timescale 1ns/1ps
module swd_link_tb
    import swd_pkg::*;
;
    // ************************************************************
    // Stimulus, observation and counters
    // ************************************************************
    logic        clk = 1'b0, sys_rst = 1'b1, sel = 1'b0, alt = 1'b0;
    logic        dme = 1'b0, stopped = 1'b0, tx_valid = 1'b0, tx_bit = 1'b0;
    logic        req_valid = 1'b0, req_dir = 1'b0, req_bit = 1'b0, req_sync = 1'b0;
    logic        rx_valid, cmd_abort, bg, wake, reg_ok, wd_hold, osc;
    logic        req_ready, ans_valid, ans_bit;
    logic        tx_rdy;
    logic [7:0]  rx_cmd, rx_last;
    logic [15:0] lfsr = 16'h0003; // Random source
    int          err_count = 0, compares = 0, cyc = 0, rx_n = 0, ab_n = 0;
    int          wk_n = 0, run = 0, last_run = 0, tx_n = 0;

    always #10 clk = ~clk;
    swd_link_if swd_link_if_i ();
    swd_target swd_target_i (.clk(clk), .sys_rst(sys_rst), .debug_clock_select(sel),
        .alternate_debug_clock(alt), .debug_mode_enable(dme), .cpu_stopped(stopped),
        .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_ready(tx_rdy), .rx_valid(rx_valid),
        .rx_cmd(rx_cmd), .cmd_abort(cmd_abort), .background_mode(bg), .cpu_wake(wake),
        .reg_cmd_ok(reg_ok), .watchdog_hold(wd_hold), .osc_keep(osc),
        .link(swd_link_if_i.target));
    swd_host swd_host_i (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_dir(req_dir), .req_bit(req_bit), .req_sync(req_sync), .req_ready(req_ready),
        .ans_valid(ans_valid), .ans_bit(ans_bit), .link(swd_link_if_i.host));
    swd_chk swd_chk_i (.clk(clk), .sys_rst(sys_rst), .tgt_out(swd_link_if_i.tgt_out),
        .tgt_oe(swd_link_if_i.tgt_oe), .hst_out(swd_link_if_i.hst_out),
        .hst_oe(swd_link_if_i.hst_oe), .wire_in(swd_link_if_i.wire_in));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Hang guard, a few times the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            err_count++;
            stop_test();
        end
    end
    // Pulses last a whole cycle, so the falling edge sees them settled
    always @(negedge clk) begin
        if (rx_valid === 1'b1) begin
            rx_n++;
            rx_last = rx_cmd;
        end
        if (cmd_abort === 1'b1)
            ab_n++;
        if (wake === 1'b1)
            wk_n++;
        if (tx_rdy === 1'b1)
            tx_n++;
        if (swd_link_if_i.tgt_oe === 1'b1 && swd_link_if_i.tgt_out === 1'b0)
            run++;
        else if (run != 0) begin
            last_run = run;
            run = 0;
        end
    end

    // One host slot; request held until taken, answer kept if one comes
    task automatic host_op(input logic dir, input logic b, input logic sy, output logic got);
        got = 1'bx;
        while (req_ready !== 1'b1)
            @(negedge clk);
        req_valid = 1'b1;
        req_dir = dir;
        req_bit = b;
        req_sync = sy;
        @(negedge clk);
        req_valid = 1'b0;
        while (req_ready !== 1'b1) begin
            @(negedge clk);
            if (ans_valid === 1'b1)
                got = ans_bit;
        end
    endtask
    task automatic send_byte(input logic [7:0] b, input logic want);
        logic g;
        int   n0;
        n0 = rx_n;
        for (int i = 7; i >= 0; i--)
            host_op(1'b1, b[i], 1'b0, g);
        for (int k = 0; k < 30 && rx_n == n0; k++)
            @(negedge clk);
        check("rx_count", 16'(rx_n - n0), 16'(want));
        if (want)
            check("rx_cmd", 16'(rx_last), 16'(b));
    endtask

    initial begin
        logic [7:0] c;
        logic       g;
        logic       bgx;
        int         k;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        check("strap_mode", 16'(bg), 16'h0000);
        check("osc_off", 16'(osc), 16'h0000);
        send_byte(CMD_ENTER_BG, 1'b1);
        check("bg_refused", 16'(bg), 16'h0000);
        dme = 1'b1;
        stopped = 1'b1;
        send_byte(CMD_ENTER_BG, 1'b1);
        check("wake", 16'(wk_n), 16'h0001);
        check("osc_on", 16'(osc), 16'h0001);
        bgx = 1'b1;
        // Corner codes first, then random ones; mode leaves halfway
        for (int i = 0; i < 8; i++) begin
            lfsr = next_rand(lfsr);
            c = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : lfsr[7:0];
            if (c == CMD_ENTER_BG || c == CMD_GO)
                c = c ^ 8'h01;
            if (i == 4) begin
                send_byte(CMD_GO, 1'b1);
                bgx = 1'b0;
            end
            send_byte(c, 1'b1);
            check("reg_ok", 16'(reg_ok), 16'(bgx | c[7]));
            check("wd_hold", 16'(wd_hold), 16'(bgx));
        end
        // Random return bits, zero low time measured on the target's own low drive
        for (int i = 0; i < 16; i++) begin
            lfsr = next_rand(lfsr);
            tx_valid = 1'b1;
            tx_bit = lfsr[0];
            last_run = 0;
            host_op(1'b0, 1'b0, 1'b0, g);
            tx_valid = 1'b0;
            check("ans_bit", 16'(g), 16'(lfsr[0]));
            if (!lfsr[0])
                check("zero_low", 16'(last_run), 16'(LOW_ZERO));
        end
        check("tx_taken", 16'(tx_n), 16'h0010);
        // Command left hanging after three bits must time out
        k = ab_n;
        repeat (3) host_op(1'b1, 1'b1, 1'b0, g);
        k = ab_n - k;
        check("early_abort", 16'(k), 16'h0000);
        while (ab_n == 0 && k < 800) begin
            @(negedge clk);
            k++;
        end
        check("abort_time", 16'(k >= 470 && k <= 530), 16'h0001);
        check("mode_kept", 16'(bg), 16'(bgx));
        send_byte(8'ha5, 1'b1);
        last_run = 0;
        host_op(1'b0, 1'b0, 1'b1, g);
        for (k = 0; k < 400 && last_run == 0; k++)
            @(negedge clk);
        check("sync_pulse", 16'(last_run), 16'(SYNC_PULSE));
        // Alternate source: ticking passes bytes, stopped passes none
        sel = 1'b1;
        alt = 1'b1;
        send_byte(8'h3c, 1'b1);
        alt = 1'b0;
        send_byte(8'hc3, 1'b0);
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        sel = 1'b0;
        send_byte(8'h69, 1'b1);
        check("strap_again", 16'(bg), 16'h0000);
        stop_test();
    end
endmodule
